// ### src/asei_pkg.sv
// constants, field layout and state record of the axis stop and external input block
// assumes nothing beyond a SystemVerilog compiler
package asei_pkg;
   // register addresses on the plain register port
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_MODE = 4'h1;
   localparam logic [3:0] ADDR_STAT = 4'h2;
   localparam logic [3:0] ADDR_LEVEL = 4'h3;
   // control register fields
   localparam int C_LIM_EN = 0;
   localparam int C_LIM_POL = 1;
   localparam int C_LIM_NOW = 2;
   localparam int C_STOP_EN = 3;
   localparam int C_STOP_POL = 6;
   localparam int C_STOP_NOW = 9;
   localparam int C_IDX_CLR = 12;
   // mode register fields
   localparam int M_PIN_FN = 0;
   localparam int M_IDX_OUT = 2;
   localparam int M_EXT = 3;
   localparam int M_DCC_EN = 5;
   localparam int M_OUT1 = 6;
   localparam int M_OUT0 = 7;
   // status register fields
   localparam int S_HARD_REVERSE_LIMIT_FLAG = 0;
   localparam int S_EMG = 1;
   // synchronised input positions
   localparam int I_NEAR = 0;
   localparam int I_HOME = 1;
   localparam int I_IDX = 2;
   localparam int I_LIM = 3;
   localparam int I_EXTP = 4;
   localparam int I_EXTM = 5;
   localparam int I_EMG = 6;
   localparam int N_IN = 7;
   // values after reset
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [6:0] SYNC_RST = 7'h7F;
   // shared pin functions and external drive modes
   localparam logic [1:0] PIN_MOTION = 2'h0;
   localparam logic [1:0] PIN_GPO = 2'h1;
   localparam logic [1:0] PIN_DCC = 2'h2;
   localparam logic [1:0] EXT_FIXED = 2'h1;
   localparam logic [1:0] EXT_CONT = 2'h2;

   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
      logic [6:0] prv;
      logic [15:0] ctrl;
      logic [15:0] mode;
      logic emg_flag;
      logic hard_reverse_limit_flag;
      logic [15:0] rdata;
      logic stop_decel;
      logic stop_now;
      logic clr_pos;
      logic start_p;
      logic start_m;
      logic run_p;
      logic run_m;
      logic shared;
      logic idx_out;
      logic idx_oe_n;
      logic [2:0] home_sense;
   } asei_state_s;
endpackage

// ### src/asei_axis_stop.sv
// stop, limit, shared pin and external start logic of one axis
// assumes the pulse generator runs on i_clk and reports pulsing and direction,
// and that pins arrive asynchronously and are pulled up when idle
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module asei_axis_stop
   import asei_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // pins
   input wire logic i_minus_limit_input,
   input wire logic i_near_home_stop_input,
   input wire logic i_home_stop_input,
   input wire logic i_index_stop_input,
   output logic o_spare_output_one,
   output logic o_spare_output_one_oe_n,
   output logic o_motion_active_output,
   input wire logic i_ext_plus_start_input,
   input wire logic i_ext_minus_start_input,
   input wire logic i_emergency_halt_input,
   // pulse generator and home search, same clock
   input wire logic i_pulsing,
   input wire logic i_dir_minus,
   input wire logic i_home_search,
   input wire logic i_dcc_request,
   output logic o_stop_decel,
   output logic o_stop_now,
   output logic o_clear_real_pos,
   output logic o_start_plus,
   output logic o_start_minus,
   output logic o_run_plus,
   output logic o_run_minus,
   output logic [2:0] o_home_sense
);

   asei_state_s st;
   asei_state_s next_st;

   // true when a pin level matches its chosen active level (pol 1 = active high)
   function automatic logic asei_active(input logic lvl, input logic pol);
      return lvl == pol;
   endfunction

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [6:0] raw;
      logic lim_act;
      logic lim_hit;
      logic [2:0] stop_act;
      logic [2:0] stop_hit;
      logic emg_act;
      logic now_any;
      logic dec_any;
      logic idx_rise;
      logic fall_p;
      logic fall_m;
      logic [1:0] ext;
      raw = '0;
      lim_act = 1'h0;
      lim_hit = 1'h0;
      stop_act = 3'h0;
      stop_hit = 3'h0;
      emg_act = 1'h0;
      now_any = 1'h0;
      dec_any = 1'h0;
      idx_rise = 1'h0;
      fall_p = 1'h0;
      fall_m = 1'h0;
      ext = 2'h0;
      next_st = st;

      raw[I_NEAR] = i_near_home_stop_input;
      raw[I_HOME] = i_home_stop_input;
      raw[I_IDX] = i_index_stop_input;
      raw[I_LIM] = i_minus_limit_input;
      raw[I_EXTP] = i_ext_plus_start_input;
      raw[I_EXTM] = i_ext_minus_start_input;
      raw[I_EMG] = i_emergency_halt_input;

      // two stages; pulses of two clocks or more survive this path
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.prv = st.s2;

      lim_act = st.ctrl[C_LIM_EN] && asei_active(st.s2[I_LIM], st.ctrl[C_LIM_POL]);
      lim_hit = lim_act && i_pulsing && i_dir_minus;
      for (int i = 0; i < 3; i++) begin
         stop_act[i] = st.ctrl[C_STOP_EN + i]
            && asei_active(st.s2[I_NEAR + i], st.ctrl[C_STOP_POL + i]);
      end
      // during home search the sensors steer the search, not a plain stop
      stop_hit = i_home_search ? 3'h0 : stop_act;
      next_st.home_sense = i_home_search ? stop_act : 3'h0;
      if (st.mode[M_IDX_OUT]) begin
         stop_hit[I_IDX] = 1'h0;
         next_st.home_sense[I_IDX] = 1'h0;
      end

      emg_act = !st.s2[I_EMG];
      now_any = emg_act
         || (lim_hit && st.ctrl[C_LIM_NOW])
         || |(stop_hit & st.ctrl[C_STOP_NOW +: 3]);
      dec_any = lim_hit || |stop_hit;
      next_st.stop_now = now_any;
      next_st.stop_decel = dec_any && !now_any;

      next_st.hard_reverse_limit_flag = lim_act;

      idx_rise = st.s2[I_IDX] && !st.prv[I_IDX];
      next_st.clr_pos = idx_rise && st.ctrl[C_IDX_CLR] && !st.mode[M_IDX_OUT];

      // external start; refused while the emergency input is low
      ext = st.mode[M_EXT +: 2];
      fall_p = !st.s2[I_EXTP] && st.prv[I_EXTP];
      fall_m = !st.s2[I_EXTM] && st.prv[I_EXTM];
      next_st.start_p = (ext == EXT_FIXED) && fall_p && !emg_act;
      next_st.start_m = (ext == EXT_FIXED) && fall_m && !emg_act;
      next_st.run_p = (ext == EXT_CONT) && !st.s2[I_EXTP] && !emg_act;
      next_st.run_m = (ext == EXT_CONT) && !st.s2[I_EXTM] && !emg_act;

      case (st.mode[M_PIN_FN +: 2])
         PIN_GPO: begin
            next_st.shared = st.mode[M_OUT0];
         end
         PIN_DCC: begin
            next_st.shared = i_dcc_request && st.mode[M_DCC_EN];
         end
         default: begin
            next_st.shared = i_pulsing;
         end
      endcase

      next_st.idx_out = st.mode[M_OUT1];
      next_st.idx_oe_n = !st.mode[M_IDX_OUT];

      // register writes
      if (i_wr) begin
         case (i_addr)
            ADDR_CTRL: begin
               next_st.ctrl = i_wdata;
            end
            ADDR_MODE: begin
               next_st.mode = i_wdata;
            end
            default: begin
            end
         endcase
      end

      // emergency flag: write 1 clears, a fresh emergency wins over the clear
      if (i_wr && i_addr == ADDR_STAT && i_wdata[S_EMG]) begin
         next_st.emg_flag = 1'h0;
      end
      if (emg_act) begin
         next_st.emg_flag = 1'h1;
      end

      // register reads; data only in the cycle after the strobe
      next_st.rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            ADDR_CTRL: begin
               next_st.rdata = st.ctrl;
            end
            ADDR_MODE: begin
               next_st.rdata = st.mode;
            end
            ADDR_STAT: begin
               next_st.rdata[S_HARD_REVERSE_LIMIT_FLAG] = st.hard_reverse_limit_flag;
               next_st.rdata[S_EMG] = st.emg_flag;
            end
            ADDR_LEVEL: begin
               next_st.rdata[N_IN-1:0] = st.s2;
            end
            default: begin
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // reset overrides the clock enable so the pins settle even when frozen
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st <= '0;
         st.s1 <= SYNC_RST;
         st.s2 <= SYNC_RST;
         st.prv <= SYNC_RST;
         st.ctrl <= CTRL_RST;
         st.mode <= MODE_RST;
         st.idx_oe_n <= 1'h1;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
   assign o_spare_output_one = st.idx_out;
   assign o_spare_output_one_oe_n = st.idx_oe_n;
   assign o_motion_active_output = st.shared;
   assign o_stop_decel = st.stop_decel;
   assign o_stop_now = st.stop_now;
   assign o_clear_real_pos = st.clr_pos;
   assign o_start_plus = st.start_p;
   assign o_start_minus = st.start_m;
   assign o_run_plus = st.run_p;
   assign o_run_minus = st.run_m;
   assign o_home_sense = st.home_sense;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   emg_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !i_emergency_halt_input) ##1 i_ce [*3] |-> st.stop_now)
      else $error("emergency did not stop the axis");

   emg_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !st.s2[I_EMG]) |=> st.emg_flag)
      else $error("emergency flag not set");

   lim_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.stop_decel) |-> $past(i_pulsing && i_dir_minus) || |$past(st.ctrl[5:3]))
      else $error("limit stop outside minus drive");

   lim_kind_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.ctrl[C_LIM_EN] && st.ctrl[C_LIM_NOW]
         && asei_active(st.s2[I_LIM], st.ctrl[C_LIM_POL]) && i_pulsing && i_dir_minus)
      |=> st.stop_now && !st.stop_decel)
      else $error("limit sudden stop missing");

   hard_reverse_limit_flag_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_rd && i_addr == ADDR_STAT) |=> o_rdata[S_HARD_REVERSE_LIMIT_FLAG] == $past(st.hard_reverse_limit_flag))
      else $error("reverse limit flag read wrong");

   idx_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.s2[I_IDX] && !st.prv[I_IDX] && st.ctrl[C_IDX_CLR] && !st.mode[M_IDX_OUT])
      |=> o_clear_real_pos)
      else $error("index edge did not clear position");

   ext_fixed_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_start_plus |-> $past(st.mode[M_EXT +: 2] == EXT_FIXED && st.prv[I_EXTP]
         && !st.s2[I_EXTP]))
      else $error("fixed start without falling edge");

   ext_cont_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.mode[M_EXT +: 2] == EXT_CONT && !st.s2[I_EXTM] && st.s2[I_EMG])
      |=> o_run_minus)
      else $error("continuous minus run missing");

   motion_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.mode[M_PIN_FN +: 2] == PIN_MOTION) |=> o_motion_active_output == $past(i_pulsing))
      else $error("motion status pin wrong");

   dcc_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && st.mode[M_PIN_FN +: 2] == PIN_DCC && !st.mode[M_DCC_EN]) |=> !o_motion_active_output)
      else $error("deviation clear while disabled");

   reset_pins_a: assert property (@(posedge i_clk)
      !i_rst_n |=> o_spare_output_one_oe_n && st.mode[M_PIN_FN +: 2] == PIN_MOTION)
      else $error("pin functions wrong after reset");

endmodule

`default_nettype wire

// ### test/asei_field.sv
// partner model: limit switch, sensors and operator panel behind the pins
// assumes pins idle high (pulled up) and the bench names target levels
`timescale 1ns/10ps
`default_nettype none

module asei_field
   import asei_pkg::*;
(
   input wire logic i_clk,
   input wire logic [6:0] i_tgt,
   output logic [6:0] o_pin
);
   // a level is held at least four clocks before the next change
   // initial values by declaration so that one process alone drives each level
   logic [1:0] held = 2'h0;
   logic [6:0] lvl = SYNC_RST;
   assign o_pin = lvl;
   always @(posedge i_clk) begin
      if (held != 2'h3) begin
         held <= held + 2'h1;
      end else if (i_tgt != lvl) begin
         lvl <= i_tgt;
         held <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// ### test/tb.sv
// testbench of the axis stop block: register reads are checked from a queue
// assumes the partner model drives the pins and the bench plays the pulse generator
`timescale 1ns/10ps
`default_nettype none

module tb;
   import asei_pkg::*;
   logic i_clk, i_rst_n, i_wr, i_rd, rd_d, i_pulsing, i_dir_minus, i_home_search, i_dcc_request;
   logic ce;
   logic [3:0] i_addr;
   logic [15:0] i_wdata, o_rdata, rnd;
   logic [6:0] tgt, pin;
   logic spare, spare_oe_n, motion, s_decel, s_now, clr, st_p, st_m, run_p, run_m, idx_wire;
   logic [2:0] home_sense;
   logic [15:0] exp_q[$];
   logic [31:0] seed;
   int num_errors, checks_done, cnt;

   asei_field field_u (.i_clk(i_clk), .i_tgt(tgt), .o_pin(pin));
   // the index wire is driven by the block whenever its enable is low
   assign idx_wire = spare_oe_n ? pin[I_IDX] : spare;
   asei_axis_stop dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_minus_limit_input(pin[I_LIM]), .i_near_home_stop_input(pin[I_NEAR]),
      .i_home_stop_input(pin[I_HOME]), .i_index_stop_input(idx_wire),
      .o_spare_output_one(spare), .o_spare_output_one_oe_n(spare_oe_n),
      .o_motion_active_output(motion), .i_ext_plus_start_input(pin[I_EXTP]),
      .i_ext_minus_start_input(pin[I_EXTM]), .i_emergency_halt_input(pin[I_EMG]),
      .i_pulsing(i_pulsing), .i_dir_minus(i_dir_minus), .i_home_search(i_home_search),
      .i_dcc_request(i_dcc_request), .o_stop_decel(s_decel), .o_stop_now(s_now),
      .o_clear_real_pos(clr), .o_start_plus(st_p), .o_start_minus(st_m), .o_run_plus(run_p),
      .o_run_minus(run_m), .o_home_sense(home_sense));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   // counts cycles with the selected pulse output high over a fixed window
   task automatic pulses(input int k);
      logic [2:0] pv;
      cnt = 0;
      repeat (12) begin
         @(negedge i_clk);
         pv = {clr, st_m, st_p};
         if (pv[k] === 1'b1) cnt++;
      end
   endtask

   // ----------------------------------------
   // read data checker
   // ----------------------------------------
   always @(posedge i_clk) rd_d <= i_rd;
   always @(negedge i_clk) begin
      if (rd_d === 1'b1 && exp_q.size() > 0) chk(o_rdata, exp_q.pop_front());
   end

   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      #2000000;
      num_errors++;
      test_done;
   end

   initial begin
      {i_rst_n, i_wr, i_rd, i_pulsing, i_dir_minus, i_home_search, i_dcc_request} = '0;
      ce = 1'b1;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      tgt = SYNC_RST;
      seed = 32'hc8a6_4603;
      num_errors = 0;
      checks_done = 0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wt(1);
      chk(16'(spare_oe_n), 16'h0001);
      @(posedge i_clk);
      i_pulsing <= 1'b1;
      wt(2);
      chk(16'(motion), 16'h0001);
      rd(ADDR_MODE, MODE_RST);
      rd(ADDR_CTRL, CTRL_RST);
      seed = lfsr(seed);
      rnd = seed[15:0];
      wr(4'h9, rnd);
      rd(4'hE, 16'h0000);
      rd(ADDR_CTRL, CTRL_RST);
      // emergency stop, sticky flag and its clear
      tgt[I_EMG] <= 1'b0;
      wt(8);
      chk(16'(s_now), 16'h0001);
      rd(ADDR_STAT, 16'h0002);
      rd(ADDR_LEVEL, 16'h003F);
      tgt[I_EMG] <= 1'b1;
      wt(8);
      chk(16'(s_now), 16'h0000);
      rd(ADDR_STAT, 16'h0002);
      wr(ADDR_STAT, 16'h0002);
      rd(ADDR_STAT, 16'h0000);
      // minus limit, active low, only while moving minus
      wr(ADDR_CTRL, 16'h0001);
      tgt[I_LIM] <= 1'b0;
      wt(8);
      chk(16'(s_decel), 16'h0000);
      rd(ADDR_STAT, 16'h0001);
      i_dir_minus <= 1'b1;
      wt(4);
      chk(16'(s_decel), 16'h0001);
      wr(ADDR_CTRL, 16'h0005);
      wt(4);
      chk(16'({s_now, s_decel}), 16'h0002);
      wr(ADDR_CTRL, 16'h0003);
      rd(ADDR_STAT, 16'h0000);
      i_dir_minus <= 1'b0;
      tgt[I_LIM] <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CTRL, 16'h0001 << (C_STOP_EN + k));
         tgt[k] <= 1'b0;
         wt(8);
         chk(16'({s_now, s_decel}), 16'h0001);
         rd(ADDR_LEVEL, 16'h007F & ~(16'h0001 << k));
         i_home_search <= 1'b1;
         wt(4);
         chk(16'(home_sense), 16'h0001 << k);
         @(posedge i_clk);
         i_home_search <= 1'b0;
         wr(ADDR_CTRL, (16'h0001 << (C_STOP_EN + k)) | (16'h0001 << (C_STOP_NOW + k)));
         wt(4);
         chk(16'({s_now, s_decel}), 16'h0002);
         tgt[k] <= 1'b1;
         wt(8);
      end
      wr(ADDR_CTRL, 16'h0001 << C_IDX_CLR);
      tgt[I_IDX] <= 1'b0;
      wt(8);
      tgt[I_IDX] <= 1'b1;
      pulses(2);
      chk(16'(cnt), 16'h0001);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_MODE, 16'(EXT_FIXED) << M_EXT);
         tgt[I_EXTP + k] <= 1'b0;
         pulses(k);
         chk(16'(cnt), 16'h0001);
         tgt[I_EXTP + k] <= 1'b1;
         wt(8);
         wr(ADDR_MODE, 16'(EXT_CONT) << M_EXT);
         tgt[I_EXTP + k] <= 1'b0;
         wt(8);
         chk(16'({run_m, run_p}), 16'h0001 << k);
         tgt[I_EXTP + k] <= 1'b1;
         wt(8);
         chk(16'({run_m, run_p}), 16'h0000);
      end
      // shared pin functions and index pin as output
      @(posedge i_clk);
      i_pulsing <= 1'b0;
      wr(ADDR_MODE, 16'(PIN_GPO) | (16'h0001 << M_OUT0));
      wt(3);
      chk(16'(motion), 16'h0001);
      i_dcc_request <= 1'b1;
      wr(ADDR_MODE, 16'(PIN_DCC) | (16'h0001 << M_DCC_EN));
      wt(3);
      chk(16'(motion), 16'h0001);
      wr(ADDR_MODE, 16'(PIN_DCC));
      wt(3);
      chk(16'(motion), 16'h0000);
      wr(ADDR_MODE, (16'h0001 << M_IDX_OUT) | (16'h0001 << M_OUT1));
      wt(3);
      chk(16'({spare_oe_n, spare}), 16'h0001);
      // a frozen block ignores a write; control keeps the index clear setting
      @(posedge i_clk);
      ce <= 1'b0;
      seed = lfsr(seed);
      wr(ADDR_CTRL, seed[15:0]);
      ce <= 1'b1;
      rd(ADDR_CTRL, 16'h0001 << C_IDX_CLR);
      wt(2);
      test_done;
   end
endmodule
`default_nettype wire
